// *** verilog/stq_pkg.sv ***
// Constants, command codes and carriers for the status query command unit.
// Assumes commands arrive already parsed into opcode, channel and argument.
package stq_pkg;

    // ***************************************************************
    // Sizes
    // ***************************************************************
    localparam int MAX_CH = 3;
    localparam int ERR_DEPTH = 4;
    localparam int ERR_CNT_W = 3;

    // ***************************************************************
    // Bit positions and reset values
    // ***************************************************************
    localparam int STB_OPER_BIT = 7;
    localparam int STB_MSS_BIT = 6;
    localparam int STB_ESB_BIT = 5;
    localparam int STB_MAV_BIT = 4;
    localparam int STB_QUESTIONABLE_SUMMARY_BIT_BIT = 3;
    localparam int STB_EAV_BIT = 2;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] KEY_RESET = 8'h00;
    localparam logic REMOTE_RESET = 1'b0;

    // ***************************************************************
    // Error codes and key codes
    // ***************************************************************
    localparam logic [7:0] ERR_NONE = 8'h00;
    localparam logic [7:0] ERR_NO_INPUT = 8'h6E;
    localparam logic [7:0] ERR_BAD_CHANNEL = 8'h72;
    localparam logic [7:0] ERR_BAD_KEY = 8'h73;
    localparam logic [7:0] ERR_KEY_REMOTE = 8'h74;
    localparam logic [7:0] KEY_FIRST = 8'h01;
    localparam logic [7:0] KEY_LAST = 8'h1A;
    localparam logic [7:0] KEY_SHIFT_CODE = 8'h40;
    localparam logic [7:0] VOLTAGE_SET_BUTTON_CODE = 8'h01;
    localparam logic [7:0] CURRENT_SET_BUTTON_CODE = 8'h02;

    // ***************************************************************
    // Types
    // ***************************************************************
    typedef logic [7:0] stq_byte_t;
    typedef logic [MAX_CH-1:0][7:0] stq_chbytes_t;

    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_OPER_CH_EVENT_Q = 4'h1,
        OP_QUESTIONABLE_SUMMARY_BIT_ENABLE_W = 4'h2,
        OP_QUESTIONABLE_SUMMARY_BIT_ENABLE_Q = 4'h3,
        OP_QUESTIONABLE_SUMMARY_BIT_EVENT_Q = 4'h4,
        OP_QUESTIONABLE_SUMMARY_BIT_CH_COND_Q = 4'h5,
        OP_QUESTIONABLE_SUMMARY_BIT_CH_ENABLE_W = 4'h6,
        OP_QUESTIONABLE_SUMMARY_BIT_CH_ENABLE_Q = 4'h7,
        OP_QUESTIONABLE_SUMMARY_BIT_CH_EVENT_Q = 4'h8,
        OP_STB_Q = 4'h9,
        OP_ERROR_Q = 4'hA,
        OP_KEY_W = 4'hB,
        OP_KEY_Q = 4'hC,
        OP_LOCAL = 4'hD,
        OP_REMOTE = 4'hE,
        OP_CLEAR_STATUS = 4'hF
    } stq_op_e;

    typedef enum logic [2:0] {
        TXT_NO_ERROR = 3'h0,
        TXT_NO_INPUT = 3'h1,
        TXT_BAD_CHANNEL = 3'h2,
        TXT_BAD_KEY = 3'h3,
        TXT_KEY_REMOTE = 3'h4
    } stq_text_e;

    typedef struct packed {
        logic valid;
        stq_op_e op;
        logic [1:0] channel;
        stq_byte_t arg;
    } stq_cmd_s;

    typedef struct packed {
        logic valid;
        stq_byte_t value;
        stq_text_e textId;
    } stq_resp_s;

    typedef struct packed {
        logic remote;
        stq_byte_t quesMask;
        stq_byte_t quesEvent;
        stq_byte_t quesPrev;
        stq_chbytes_t chMask;
        stq_chbytes_t chQuesEvent;
        stq_chbytes_t chQuesPrev;
        stq_chbytes_t chOperEvent;
        stq_chbytes_t chOperPrev;
        logic [ERR_DEPTH-1:0][7:0] errQueue;
        logic [ERR_CNT_W-1:0] errCount;
        stq_byte_t lastKey;
        stq_resp_s resp;
        logic keyStrobe;
        stq_byte_t keyCode;
    } stq_state_s;

    function automatic stq_text_e errText(input stq_byte_t code);
        case (code)
            ERR_NO_INPUT: errText = TXT_NO_INPUT;
            ERR_BAD_CHANNEL: errText = TXT_BAD_CHANNEL;
            ERR_BAD_KEY: errText = TXT_BAD_KEY;
            ERR_KEY_REMOTE: errText = TXT_KEY_REMOTE;
            default: errText = TXT_NO_ERROR;
        endcase
    endfunction

    function automatic logic keyValid(input stq_byte_t code);
        keyValid = (code >= KEY_FIRST && code <= KEY_LAST) ||
                   code == KEY_SHIFT_CODE;
    endfunction

endpackage

// *** verilog/stq_status_query_command_unit.sv ***
// Status query command unit: status registers, error queue, key and local.
// Assumes a parser upstream hands over one decoded command per cycle and
// that channel conditions and summary inputs are synchronous to clk.
//
// What this block does
// R1: Channel operation event query returns 0..255
// R2: Channel index 1..3, or 1..2 on two-channel
// R3: Eight-bit mask gates events onto summary bit
// R4: Questionable event query clears that register
// R5: Mask write loads value; query returns it
// R6: Mask 8 passes only remote inhibit transitions
// R7: Channel condition query returns live condition bits
// R8: Channel questionable event query returns latched events
// R9: Operation event value 9: output on, CV
// R10: Separate questionable mask kept per channel
// R11: Status byte query includes master summary bit
// R12: Error query returns code plus text identifier
// R13: Key press acted on only under local
// R14: Key codes 1..26 and 64 accepted
// R15: Local command leaves remote control
// R16: Summary at bit 3; bits 1,0 zero
// R17: Events stay latched until read or cleared
`timescale 1ns/1ps

module stq_status_query_command_unit #(
    parameter int NUM_CHANNELS = 3
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire stq_pkg::stq_cmd_s cmd,
    input wire stq_pkg::stq_byte_t quesCondition,
    input wire stq_pkg::stq_chbytes_t chQuesCondition,
    input wire stq_pkg::stq_chbytes_t chOperCondition,
    input wire logic operSummary,
    input wire logic eventStatusSummary,
    input wire logic messageAvailable,
    input wire stq_pkg::stq_byte_t serviceRequestEnable,
    output stq_pkg::stq_resp_s resp,
    output logic keyPress,
    output stq_pkg::stq_byte_t keyCode,
    output logic remoteMode
);
    import stq_pkg::*;

    // ***************************************************************
    // State
    // ***************************************************************
    stq_state_s state;
    stq_state_s next_state;

    logic [MAX_CH-1:0] chSummary;
    logic [MAX_CH-1:0] chPresent;
    logic questionableSummaryBit;
    logic masterSummaryBit;
    stq_byte_t statusSummaryByte;
    stq_byte_t stbNoMaster;
    logic [1:0] chIdx;
    logic chOk;
    logic take;

    // ***************************************************************
    // Per-channel summary and presence
    // ***************************************************************
    generate
        for (genvar c = 0; c < MAX_CH; c++) begin : gChan
            assign chPresent[c] = (c < NUM_CHANNELS); // R2
            assign chSummary[c] = chPresent[c] &&
                |(state.chQuesEvent[c] & state.chMask[c]); // R10
        end
    endgenerate

    // ***************************************************************
    // Status byte
    // ***************************************************************
    assign questionableSummaryBit = |(state.quesEvent & state.quesMask) ||
        |chSummary; // R3 R6

    always_comb begin
        stbNoMaster = 8'h00; // R16
        stbNoMaster[STB_OPER_BIT] = operSummary;
        stbNoMaster[STB_ESB_BIT] = eventStatusSummary;
        stbNoMaster[STB_MAV_BIT] = messageAvailable;
        stbNoMaster[STB_QUESTIONABLE_SUMMARY_BIT_BIT] = questionableSummaryBit; // R16
        stbNoMaster[STB_EAV_BIT] = (state.errCount != '0);
    end

    assign masterSummaryBit = |(stbNoMaster & serviceRequestEnable &
        ~(8'h01 << STB_MSS_BIT));

    always_comb begin
        statusSummaryByte = stbNoMaster;
        statusSummaryByte[STB_MSS_BIT] = masterSummaryBit; // R11
    end

    // ***************************************************************
    // Command decode
    // ***************************************************************
    assign take = cmd.valid;
    assign chIdx = cmd.channel - 2'h1;
    assign chOk = cmd.channel != 2'h0 &&
        int'(cmd.channel) <= NUM_CHANNELS; // R2

    always_comb begin
        logic pushErr;
        logic popErr;
        stq_byte_t errCode;
        pushErr = 1'b0;
        popErr = 1'b0;
        errCode = ERR_NONE;
        next_state = state;
        next_state.resp.valid = 1'b0;
        next_state.keyStrobe = 1'b0;

        // Latch rising condition bits; set wins over a clearing read
        next_state.quesPrev = quesCondition;
        next_state.chQuesPrev = chQuesCondition;
        next_state.chOperPrev = chOperCondition;

        if (take) begin
            unique case (cmd.op)
                OP_OPER_CH_EVENT_Q, OP_QUESTIONABLE_SUMMARY_BIT_CH_COND_Q, OP_QUESTIONABLE_SUMMARY_BIT_CH_ENABLE_W,
                OP_QUESTIONABLE_SUMMARY_BIT_CH_ENABLE_Q, OP_QUESTIONABLE_SUMMARY_BIT_CH_EVENT_Q: begin
                    if (!chOk) begin
                        pushErr = 1'b1; // R2
                        errCode = ERR_BAD_CHANNEL;
                    end
                end
                default: begin
                end
            endcase

            if (!pushErr) begin
                unique case (cmd.op)
                    OP_NONE: begin
                        pushErr = 1'b1; // R12
                        errCode = ERR_NO_INPUT;
                    end
                    OP_OPER_CH_EVENT_Q: begin
                        next_state.resp.valid = 1'b1;
                        next_state.resp.value =
                            state.chOperEvent[chIdx]; // R1 R9
                        next_state.chOperEvent[chIdx] = 8'h00; // R17
                    end
                    OP_QUESTIONABLE_SUMMARY_BIT_ENABLE_W: begin
                        next_state.quesMask = cmd.arg; // R5
                    end
                    OP_QUESTIONABLE_SUMMARY_BIT_ENABLE_Q: begin
                        next_state.resp.valid = 1'b1;
                        next_state.resp.value = state.quesMask; // R5
                    end
                    OP_QUESTIONABLE_SUMMARY_BIT_EVENT_Q: begin
                        next_state.resp.valid = 1'b1;
                        next_state.resp.value = state.quesEvent;
                        next_state.quesEvent = 8'h00; // R4
                    end
                    OP_QUESTIONABLE_SUMMARY_BIT_CH_COND_Q: begin
                        next_state.resp.valid = 1'b1;
                        next_state.resp.value =
                            chQuesCondition[chIdx]; // R7
                    end
                    OP_QUESTIONABLE_SUMMARY_BIT_CH_ENABLE_W: begin
                        next_state.chMask[chIdx] = cmd.arg; // R10
                    end
                    OP_QUESTIONABLE_SUMMARY_BIT_CH_ENABLE_Q: begin
                        next_state.resp.valid = 1'b1;
                        next_state.resp.value = state.chMask[chIdx]; // R10
                    end
                    OP_QUESTIONABLE_SUMMARY_BIT_CH_EVENT_Q: begin
                        next_state.resp.valid = 1'b1;
                        next_state.resp.value =
                            state.chQuesEvent[chIdx]; // R8
                        next_state.chQuesEvent[chIdx] = 8'h00; // R4
                    end
                    OP_STB_Q: begin
                        next_state.resp.valid = 1'b1;
                        next_state.resp.value = statusSummaryByte; // R11
                    end
                    OP_ERROR_Q: begin
                        popErr = 1'b1;
                        next_state.resp.valid = 1'b1;
                        next_state.resp.value = (state.errCount != '0) ?
                            state.errQueue[0] : ERR_NONE; // R12
                        next_state.resp.textId =
                            errText(next_state.resp.value); // R12
                    end
                    OP_KEY_W: begin
                        if (!keyValid(cmd.arg)) begin
                            pushErr = 1'b1; // R14
                            errCode = ERR_BAD_KEY;
                        end else if (state.remote) begin
                            pushErr = 1'b1; // R13
                            errCode = ERR_KEY_REMOTE;
                        end else begin
                            next_state.keyStrobe = 1'b1; // R13
                            next_state.keyCode = cmd.arg;
                            next_state.lastKey = cmd.arg;
                        end
                    end
                    OP_KEY_Q: begin
                        next_state.resp.valid = 1'b1;
                        next_state.resp.value = state.lastKey;
                    end
                    OP_LOCAL: begin
                        next_state.remote = 1'b0; // R15
                    end
                    OP_REMOTE: begin
                        next_state.remote = 1'b1;
                    end
                    OP_CLEAR_STATUS: begin
                        next_state.quesEvent = 8'h00; // R17
                        next_state.chQuesEvent = '0;
                        next_state.chOperEvent = '0;
                        next_state.errCount = '0;
                    end
                    default: begin
                    end
                endcase
            end
            if (cmd.op != OP_ERROR_Q) begin
                next_state.resp.textId = TXT_NO_ERROR;
            end
        end

        // Event latches: new transitions always land after any clear
        next_state.quesEvent = next_state.quesEvent |
            (quesCondition & ~state.quesPrev); // R17
        next_state.chQuesEvent = next_state.chQuesEvent |
            (chQuesCondition & ~state.chQuesPrev); // R17
        next_state.chOperEvent = next_state.chOperEvent |
            (chOperCondition & ~state.chOperPrev); // R17

        // Error queue: pop from head, push at tail, drop when full
        if (popErr && state.errCount != '0) begin
            for (int i = 0; i < ERR_DEPTH - 1; i++) begin
                next_state.errQueue[i] = state.errQueue[i + 1];
            end
            next_state.errCount = state.errCount - 1'b1;
        end
        if (pushErr && int'(state.errCount) < ERR_DEPTH) begin
            next_state.errQueue[state.errCount[1:0]] = errCode; // R12
            next_state.errCount = state.errCount + 1'b1;
        end
    end

    // ***************************************************************
    // Registers
    // ***************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            state <= '0;
            state.remote <= REMOTE_RESET;
            state.quesMask <= MASK_RESET;
            state.lastKey <= KEY_RESET;
        end else if (ce) begin
            state <= next_state;
        end
    end

    // ***************************************************************
    // Outputs
    // ***************************************************************
    assign resp = state.resp;
    assign keyPress = state.keyStrobe;
    assign keyCode = state.keyCode;
    assign remoteMode = state.remote;

endmodule // stq_status_query_command_unit

// *** sim/stq_chk.sv ***
// Port checker for the status query command unit.
// Assumes stq_pkg is compiled first; bound into the unit at the foot.
`timescale 1ns/1ps

module stq_chk #(
    parameter int NUM_CHANNELS = 3
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire stq_pkg::stq_cmd_s cmd,
    input wire stq_pkg::stq_byte_t quesCondition,
    input wire stq_pkg::stq_chbytes_t chQuesCondition,
    input wire stq_pkg::stq_chbytes_t chOperCondition,
    input wire logic operSummary,
    input wire logic eventStatusSummary,
    input wire logic messageAvailable,
    input wire stq_pkg::stq_byte_t serviceRequestEnable,
    input wire stq_pkg::stq_resp_s resp,
    input wire logic keyPress,
    input wire stq_pkg::stq_byte_t keyCode,
    input wire logic remoteMode
);
    import stq_pkg::*;
    // ***************************************************************
    // Checks
    // ***************************************************************
    logic take;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    assign take = ce && cmd.valid;

    stb_layout_a: assert property (
        take && cmd.op == OP_STB_Q |=> resp.valid && resp.value[1:0] == 2'h0
        && resp.value[7] == $past(operSummary)
        && resp.value[5] == $past(eventStatusSummary)) else $error("stb bits");
    mask_echo_a: assert property (
        take && cmd.op == OP_QUESTIONABLE_SUMMARY_BIT_ENABLE_W ##1 take
        && cmd.op == OP_QUESTIONABLE_SUMMARY_BIT_ENABLE_Q |=> resp.valid
        && resp.value == $past(cmd.arg, 2)) else $error("mask readback");
    write_silent_a: assert property (
        take && cmd.op inside {OP_NONE, OP_QUESTIONABLE_SUMMARY_BIT_ENABLE_W, OP_QUESTIONABLE_SUMMARY_BIT_CH_ENABLE_W,
        OP_KEY_W, OP_LOCAL, OP_REMOTE} |=> !resp.valid) else $error("write ans");
    bad_channel_a: assert property (
        take && cmd.op == OP_QUESTIONABLE_SUMMARY_BIT_CH_COND_Q && (cmd.channel == 2'h0
        || int'(cmd.channel) > NUM_CHANNELS) |=> !resp.valid)
        else $error("bad channel answered");
    cond_live_a: assert property (
        take && cmd.op == OP_QUESTIONABLE_SUMMARY_BIT_CH_COND_Q && cmd.channel == 2'h1
        |=> resp.valid && resp.value == $past(chQuesCondition[0]))
        else $error("condition readback");
    key_remote_a: assert property (
        take && cmd.op == OP_KEY_W && remoteMode |=> !keyPress)
        else $error("key in remote");
    key_local_a: assert property (
        take && cmd.op == OP_KEY_W && !remoteMode && cmd.arg == KEY_SHIFT_CODE
        |=> keyPress && keyCode == KEY_SHIFT_CODE) else $error("key lost");
    key_bad_a: assert property (
        take && cmd.op == OP_KEY_W && cmd.arg inside {8'h00, 8'h1B}
        |=> !keyPress && $stable(keyCode)) else $error("bad key taken");
    local_cmd_a: assert property (
        take && cmd.op == OP_LOCAL |=> !remoteMode) else $error("still remote");
endmodule // stq_chk

bind stq_status_query_command_unit stq_chk #(
    .NUM_CHANNELS(NUM_CHANNELS)
) u_chk (.*);

// *** sim/stq_host.sv ***
// Remote controller model: issues decoded commands, collects answers.
// Assumes the unit answers a query one edge after taking it.
`timescale 1ns/1ps

module stq_host (
    input wire logic clk,
    input wire stq_pkg::stq_resp_s resp,
    output stq_pkg::stq_cmd_s cmd
);
    import stq_pkg::*;
    // ***************************************************************
    // Command tasks
    // ***************************************************************
    initial cmd = '0;
    // No range check here; callers also pass bad channels and key codes
    task automatic put(input stq_op_e op, input logic [1:0] ch,
            input stq_byte_t arg);
        cmd <= '{1'b1, op, ch, arg};
        @(posedge clk);
        #1;
    endtask
    // Released argument lines do not keep the last value
    task automatic idle();
        cmd.valid <= 1'b0;
        cmd.arg <= ~cmd.arg;
        @(posedge clk);
        #1;
    endtask
    task automatic ask(input stq_op_e op, input logic [1:0] ch,
            output logic ok, output stq_resp_s r);
        put(op, ch, 8'h00);
        ok = resp.valid;
        r = resp;
        idle();
    endtask
endmodule // stq_host

// *** sim/test_status_query_command_unit.sv ***
// Self-checking bench for the status query command unit.
// Assumes stq_pkg, the unit, stq_host and stq_chk are compiled first.
`timescale 1ns/1ps
`define CHK(n, e, a) \
    check_count++; \
    if ((a) !== (e)) begin \
        err_total++; \
        $display("MISMATCH %s exp %0h got %0h", n, e, a); \
    end

module test_status_query_command_unit;
    import stq_pkg::*;
    logic clk, reset, ce, ok, keyPress, remoteMode;
    logic operSummary, eventStatusSummary, messageAvailable;
    stq_byte_t quesCondition, serviceRequestEnable, keyCode;
    stq_chbytes_t chQuesCondition, chOperCondition;
    stq_cmd_s cmd;
    stq_resp_s resp, r;
    int err_total, check_count;

    stq_status_query_command_unit #(.NUM_CHANNELS(3)) u_dut (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .cmd(cmd),
        .quesCondition(quesCondition),
        .chQuesCondition(chQuesCondition),
        .chOperCondition(chOperCondition),
        .operSummary(operSummary),
        .eventStatusSummary(eventStatusSummary),
        .messageAvailable(messageAvailable),
        .serviceRequestEnable(serviceRequestEnable),
        .resp(resp),
        .keyPress(keyPress),
        .keyCode(keyCode),
        .remoteMode(remoteMode)
    );
    stq_host u_host (.clk(clk), .resp(resp), .cmd(cmd));
    // ***************************************************************
    // Scenarios
    // ***************************************************************
    task automatic err_is(input stq_byte_t c, input stq_text_e t);
        u_host.ask(OP_ERROR_Q, 2'h0, ok, r);
        `CHK("err", {1'b1, c, t}, {ok, r.value, r.textId})
    endtask
    task automatic t_status();
        eventStatusSummary = 1'b1;
        serviceRequestEnable = 8'h20;
        u_host.ask(OP_STB_Q, 2'h0, ok, r);
        `CHK("stb", 9'h160, {ok, r.value})
        u_host.put(OP_QUESTIONABLE_SUMMARY_BIT_ENABLE_W, 2'h0, 8'h08);
        quesCondition = 8'h01;
        u_host.idle();
        u_host.ask(OP_STB_Q, 2'h0, ok, r);
        `CHK("stb", 9'h160, {ok, r.value})
        quesCondition = 8'h09;
        u_host.idle();
        u_host.ask(OP_STB_Q, 2'h0, ok, r);
        `CHK("stb", 9'h168, {ok, r.value})
        quesCondition = 8'h00;
        u_host.ask(OP_QUESTIONABLE_SUMMARY_BIT_EVENT_Q, 2'h0, ok, r);
        `CHK("qev", 9'h109, {ok, r.value})
        u_host.ask(OP_QUESTIONABLE_SUMMARY_BIT_EVENT_Q, 2'h0, ok, r);
        `CHK("qev", 9'h100, {ok, r.value})
        u_host.ask(OP_STB_Q, 2'h0, ok, r);
        `CHK("stb", 9'h160, {ok, r.value})
        $display("t_status done");
    endtask
    task automatic t_mask();
        stq_byte_t v [3];
        v = '{8'hA5, 8'hFF, 8'h00};
        foreach (v[i]) begin
            u_host.put(OP_QUESTIONABLE_SUMMARY_BIT_ENABLE_W, 2'h0, v[i]);
            u_host.ask(OP_QUESTIONABLE_SUMMARY_BIT_ENABLE_Q, 2'h0, ok, r);
            `CHK("mask", {1'b1, v[i]}, {ok, r.value})
        end
        u_host.put(OP_QUESTIONABLE_SUMMARY_BIT_CH_ENABLE_W, 2'h2, 8'h5A);
        u_host.put(OP_QUESTIONABLE_SUMMARY_BIT_CH_ENABLE_W, 2'h1, 8'hC3);
        u_host.ask(OP_QUESTIONABLE_SUMMARY_BIT_CH_ENABLE_Q, 2'h2, ok, r);
        `CHK("chmask", 9'h15A, {ok, r.value})
        u_host.ask(OP_QUESTIONABLE_SUMMARY_BIT_CH_ENABLE_Q, 2'h1, ok, r);
        `CHK("chmask", 9'h1C3, {ok, r.value})
        $display("t_mask done");
    endtask
    task automatic t_chan();
        chQuesCondition[0] = 8'h01;
        chQuesCondition[2] = 8'h02;
        chOperCondition[1] = 8'h09;
        u_host.idle();
        u_host.ask(OP_QUESTIONABLE_SUMMARY_BIT_CH_COND_Q, 2'h1, ok, r);
        `CHK("cond", 9'h101, {ok, r.value})
        u_host.ask(OP_QUESTIONABLE_SUMMARY_BIT_CH_EVENT_Q, 2'h3, ok, r);
        `CHK("chev", 9'h102, {ok, r.value})
        u_host.ask(OP_QUESTIONABLE_SUMMARY_BIT_CH_EVENT_Q, 2'h3, ok, r);
        `CHK("chev", 9'h100, {ok, r.value})
        u_host.ask(OP_OPER_CH_EVENT_Q, 2'h2, ok, r);
        `CHK("oper", 9'h109, {ok, r.value})
        u_host.ask(OP_OPER_CH_EVENT_Q, 2'h2, ok, r);
        `CHK("oper", 9'h100, {ok, r.value})
        u_host.ask(OP_QUESTIONABLE_SUMMARY_BIT_CH_COND_Q, 2'h0, ok, r);
        `CHK("chan0", 1'b0, ok)
        u_host.put(OP_NONE, 2'h0, 8'h00);
        err_is(ERR_BAD_CHANNEL, TXT_BAD_CHANNEL);
        err_is(ERR_NO_INPUT, TXT_NO_INPUT);
        err_is(ERR_NONE, TXT_NO_ERROR);
        $display("t_chan done");
    endtask
    task automatic t_key();
        stq_byte_t k;
        for (int i = 1; i <= 27; i++) begin
            k = (i == 27) ? KEY_SHIFT_CODE : 8'(i);
            u_host.put(OP_KEY_W, 2'h0, k);
            `CHK("key", {1'b1, k}, {keyPress, keyCode})
        end
        u_host.put(OP_KEY_W, 2'h0, 8'h1B);
        `CHK("badkey", 9'h040, {keyPress, keyCode})
        u_host.put(OP_REMOTE, 2'h0, 8'h00);
        u_host.put(OP_KEY_W, 2'h0, 8'h01);
        `CHK("remote", 2'b01, {keyPress, remoteMode})
        u_host.put(OP_LOCAL, 2'h0, 8'h00);
        `CHK("local", 1'b0, remoteMode)
        u_host.put(OP_KEY_W, 2'h0, 8'h02);
        `CHK("key", 2'b10, {keyPress, remoteMode})
        u_host.ask(OP_KEY_Q, 2'h0, ok, r);
        `CHK("keyq", 9'h102, {ok, r.value})
        err_is(ERR_BAD_KEY, TXT_BAD_KEY);
        err_is(ERR_KEY_REMOTE, TXT_KEY_REMOTE);
        $display("t_key done");
    endtask
    task automatic t_misc();
        operSummary = 1'b1;
        messageAvailable = 1'b1;
        serviceRequestEnable = 8'h10;
        u_host.put(OP_CLEAR_STATUS, 2'h0, 8'h00);
        u_host.put(OP_NONE, 2'h0, 8'h00);
        u_host.ask(OP_STB_Q, 2'h0, ok, r);
        `CHK("stb", 9'h1F4, {ok, r.value})
        err_is(ERR_NO_INPUT, TXT_NO_INPUT);
        ce = 1'b0;
        u_host.put(OP_QUESTIONABLE_SUMMARY_BIT_ENABLE_Q, 2'h0, 8'h00);
        `CHK("frozen", 1'b0, resp.valid)
        ce = 1'b1;
        u_host.idle();
        $display("t_misc done");
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ***************************************************************
    // Run
    // ***************************************************************
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        #1000000;
        err_total++;
        complete_run();
    end
    initial begin
        {reset, ce, operSummary, eventStatusSummary, messageAvailable} = 5'h18;
        {quesCondition, serviceRequestEnable} = 16'h0000;
        chQuesCondition = '0;
        chOperCondition = '0;
        err_total = 0;
        check_count = 0;
        repeat (12) @(posedge clk);
        #1 reset = 1'b0;
        t_status();
        t_mask();
        t_chan();
        t_key();
        t_misc();
        complete_run();
    end
endmodule // test_status_query_command_unit
